// file: shared/pager_link_defines.svh
// What this block does
// - packet is 8-bit id plus 24 info
// - full duplex, both directions carry real packets
// - device is slave, host clocks, select low
// - host selects, waits ready low, clocks 32
// - host exchange starts only after select falls
// - host packet returns status when enabled and nothing queued
// - pending packet drives ready low for host
// - host may hold select between device packets
// - host reading with nothing sends null checksum
// - most significant bit shifted first
// - decode ids checksum, config, control, receiver settings
// - ids 1c-1f ignored, not in checksum
// - ids 20-27 frame groups, descending order
// - id 78 address enable, 80-8f addresses
// - host never sends reserved ids
// - device ids block, address, vectors, status, part
// - other packets xor info, disable output
// - reset disables output, checksum gets part id
// - disabled device offers only part id packet
// - matching checksum enables; checksum when enabled ignored
// - checksum id zero, value in low 24
`ifndef PAGER_LINK_DEFINES_SVH
`define PAGER_LINK_DEFINES_SVH

// ----------------------------------------
// packet layout
// ----------------------------------------
`define PKT_W           32
`define ID_W            8
`define INFO_W          24
`define ID_MSB          31
`define ID_LSB          24
`define CNT_W           5

// ----------------------------------------
// host-to-device identifiers
// ----------------------------------------
`define HID_CHECKSUM    8'h00
`define HID_CONFIG      8'h01
`define HID_CONTROL     8'h02
`define HID_ALLFRAME    8'h03
`define HID_RXLINE      8'h0f
`define HID_RXCFG_LO    8'h10
`define HID_RXCFG_HI    8'h1b
`define HID_SPECIAL_LO  8'h1c
`define HID_SPECIAL_HI  8'h1f
`define HID_FRAME_LO    8'h20
`define HID_FRAME_HI    8'h27
`define HID_UADDR_EN    8'h78
`define HID_UADDR_LO    8'h80
`define HID_UADDR_HI    8'h8f

// ----------------------------------------
// device-to-host identifiers
// ----------------------------------------
`define DID_BLOCK_INFO  8'h00
`define DID_ADDRESS     8'h01
`define DID_VECTOR_LO   8'h02
`define DID_VECTOR_HI   8'h57
`define DID_STATUS      8'h7f
`define DID_PART        8'hff

// ----------------------------------------
// reset values and timing counts
// ----------------------------------------
`define PART_ID_DEFAULT 24'h5a3c01
`define OUT_EN_RESET    1'b0
`define SCK_HALF_CYC    4
`define GAP_CYC         16

`endif

// file: shared/pager_link_pkg.sv
`include "pager_link_defines.svh"

package pager_link_pkg;

    // class of a packet arriving from the host
    typedef enum logic [3:0]
    {
        HK_CHECKSUM,
        HK_CONFIG,
        HK_CONTROL,
        HK_ALLFRAME,
        HK_RXLINE,
        HK_RXCFG,
        HK_SPECIAL,
        HK_FRAME,
        HK_UADDR_EN,
        HK_UADDR,
        HK_RESERVED
    } host_kind_e;

    // which source filled the outgoing word
    typedef enum logic [1:0]
    {
        TX_PART,
        TX_USER,
        TX_STATUS
    } tx_src_e;

    typedef logic [`PKT_W-1:0]  pkt_t;
    typedef logic [`INFO_W-1:0] info_t;
    typedef logic [`ID_W-1:0]   id_t;

    // identifier classification, shared by both ends
    function automatic host_kind_e host_kind(input id_t id);
        host_kind_e k;
        k = HK_RESERVED;
        if (id == `HID_CHECKSUM)                              k = HK_CHECKSUM;
        else if (id == `HID_CONFIG)                           k = HK_CONFIG;
        else if (id == `HID_CONTROL)                          k = HK_CONTROL;
        else if (id == `HID_ALLFRAME)                         k = HK_ALLFRAME;
        else if (id == `HID_RXLINE)                           k = HK_RXLINE;
        else if (id >= `HID_RXCFG_LO && id <= `HID_RXCFG_HI)  k = HK_RXCFG;
        else if (id >= `HID_SPECIAL_LO && id <= `HID_SPECIAL_HI) k = HK_SPECIAL;
        else if (id >= `HID_FRAME_LO && id <= `HID_FRAME_HI)  k = HK_FRAME;
        else if (id == `HID_UADDR_EN)                         k = HK_UADDR_EN;
        else if (id >= `HID_UADDR_LO && id <= `HID_UADDR_HI)  k = HK_UADDR;
        return k;
    endfunction

    // setting, frame group or address index carried in the id
    function automatic logic [3:0] host_index(input id_t id);
        logic [3:0] ix;
        ix = 4'h0;
        if (id >= `HID_FRAME_LO && id <= `HID_FRAME_HI)
            ix = {1'b0, 3'h7 - id[2:0]};    // group n covers frames 16n..16n+15
        else
            ix = id[3:0];
        return ix;
    endfunction

endpackage

// file: shared/pager_link_if.sv
`timescale 1ns/1ps

interface pager_link_if;
    logic ss_n;      // select, active low, host drives
    logic sck;       // serial clock, host drives
    logic mosi;      // host to device data
    logic miso;      // device to host data
    logic miso_oe;   // device drives miso while high
    logic ready_n;   // device request / ready, active low
    logic miso_pin;  // resolved line, pulled high when released

    assign miso_pin = miso_oe ? miso : 1'b1;

    modport device
    (
        input  ss_n, sck, mosi,
        output miso, miso_oe, ready_n
    );

    modport host
    (
        output ss_n, sck, mosi,
        input  miso_pin, ready_n
    );
endinterface

// file: hw/pager_dev_end.sv
`timescale 1ns/1ps
`include "pager_link_defines.svh"
module pager_dev_end
    import pager_link_pkg::*;
#(
    parameter logic [`INFO_W-1:0] PART_ID = `PART_ID_DEFAULT  // arbitrary value
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    pager_link_if.device     lnk,
    input  wire logic        tx_valid,
    input  wire pkt_t        tx_data,
    output logic             tx_ready,
    input  wire info_t       status_info,
    output logic             rx_valid,
    output host_kind_e       rx_kind,
    output logic [3:0]       rx_index,
    output info_t            rx_info,
    output logic             out_en
);

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    if (`PKT_W != `ID_W + `INFO_W)
    begin : g_bad_layout
        $error("packet width must equal id plus info width");
    end

    // ----------------------------------------
    // link domain, clocked by the host's sck
    // ----------------------------------------
    logic [`CNT_W-1:0] bit_cnt_ff;    // bit position inside the packet
    pkt_t              shift_ff;      // in and out shifter
    pkt_t              rx_word_ff;    // last whole packet, held for sys side
    logic              done_tgl_ff;   // flips once per finished packet
    pkt_t              tx_word_ff;    // sys side word, stable while ready low

    // counter restarts on every deselect, so a fresh fall frames the packet
    always_ff @(posedge lnk.sck or posedge lnk.ss_n)
    begin
        if (lnk.ss_n)
            bit_cnt_ff <= '0;
        else
            bit_cnt_ff <= bit_cnt_ff + `CNT_W'(1);
    end

    // sample mosi on the rising edge, msb first; load outgoing word at bit 0
    always_ff @(posedge lnk.sck)
    begin
        if (bit_cnt_ff == '0)
            shift_ff <= {tx_word_ff[`PKT_W-2:0], lnk.mosi};
        else
            shift_ff <= {shift_ff[`PKT_W-2:0], lnk.mosi};
    end

    // hand the finished word over; it holds for a whole packet time
    always_ff @(posedge lnk.sck or posedge rst)
    begin
        if (rst)
        begin
            done_tgl_ff <= 1'b0;
            rx_word_ff  <= '0;
        end
        else if (bit_cnt_ff == '1)
        begin
            done_tgl_ff <= ~done_tgl_ff;
            rx_word_ff  <= {shift_ff[`PKT_W-2:0], lnk.mosi};
        end
    end

    // first bit comes straight from the prepared word, then from the shifter
    assign lnk.miso    = (bit_cnt_ff == '0) ? tx_word_ff[`PKT_W-1]
                                            : shift_ff[`PKT_W-1];
    assign lnk.miso_oe = ~lnk.ss_n;

    // ----------------------------------------
    // crossing into the system clock
    // ----------------------------------------
    logic ss_s1_ff, ss_s2_ff, ss_s3_ff;   // select synchroniser and edge stage
    logic tg_s1_ff, tg_s2_ff, tg_s3_ff;   // done toggle synchroniser
    logic ss_fall;                        // select went low
    logic pkt_done;                       // one packet finished

    // two flops before use; the third stage only feeds edge detection
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            {ss_s1_ff, ss_s2_ff, ss_s3_ff} <= 3'h7;
            {tg_s1_ff, tg_s2_ff, tg_s3_ff} <= 3'h0;
        end
        else
        begin
            {ss_s1_ff, ss_s2_ff, ss_s3_ff} <= {lnk.ss_n, ss_s1_ff, ss_s2_ff};
            {tg_s1_ff, tg_s2_ff, tg_s3_ff} <= {done_tgl_ff, tg_s1_ff, tg_s2_ff};
        end
    end

    assign ss_fall  = ss_s3_ff & ~ss_s2_ff;
    assign pkt_done = tg_s2_ff ^ tg_s3_ff;

    // ----------------------------------------
    // received packet handling and checksum
    // ----------------------------------------
    id_t        rx_id;
    info_t      rx_inf;
    host_kind_e kind;
    info_t      csum_ff;      // running xor of information fields
    logic       en_ff;        // output enabled
    logic       pid_sent_ff;  // part id already read since disable

    assign rx_id  = rx_word_ff[`ID_MSB:`ID_LSB];
    assign rx_inf = rx_word_ff[`INFO_W-1:0];
    assign kind   = host_kind(rx_id);

    // enable gate: any counted packet disables, a matching checksum enables
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            csum_ff <= PART_ID;
            en_ff   <= `OUT_EN_RESET;
        end
        else if (pkt_done)
        begin
            unique case (kind)
                HK_CHECKSUM:
                    // ignored when already enabled; mismatch changes nothing
                    if (!en_ff && rx_inf == csum_ff)
                        en_ff <= 1'b1;
                HK_SPECIAL:
                    ;
                default:
                begin
                    csum_ff <= csum_ff ^ rx_inf;
                    en_ff   <= 1'b0;
                end
            endcase
        end
    end

    // deliver configuration traffic to the decoding core
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rx_valid <= 1'b0;
            rx_kind  <= HK_RESERVED;
            rx_index <= 4'h0;
            rx_info  <= '0;
        end
        else
        begin
            // reserved ids still count in the checksum but are not passed on
            rx_valid <= pkt_done && kind != HK_CHECKSUM && kind != HK_SPECIAL
                        && kind != HK_RESERVED;
            if (pkt_done)
            begin
                rx_kind  <= kind;
                rx_index <= host_index(rx_id);
                rx_info  <= rx_inf;
            end
        end
    end

    assign out_en = en_ff;

    // ----------------------------------------
    // outgoing word selection and ready
    // ----------------------------------------
    pkt_t    usr_word_ff;   // one waiting user packet
    logic    usr_full_ff;
    logic    busy_ff;       // ready is low, word handed to the link
    logic    armed_ff;      // host select fall seen, not yet served
    tx_src_e src_ff;        // where the word in flight came from
    logic    pending;       // device wants the host to read
    logic    usr_take;      // user word leaves with this packet
    logic    usr_load;
    logic    ready_n_ff;

    assign pending  = (!en_ff && !pid_sent_ff) || (en_ff && usr_full_ff);
    assign usr_take = pkt_done && busy_ff && src_ff == TX_USER;
    assign usr_load = tx_valid && tx_ready;

    // select arms a host exchange; a fall in the done cycle is kept
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            armed_ff <= 1'b0;
        else if (ss_fall)
            armed_ff <= 1'b1;
        else if (pkt_done)
            armed_ff <= 1'b0;
    end

    // load a word and drop ready; raise it when the packet is done
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            busy_ff    <= 1'b0;
            ready_n_ff <= 1'b1;
            src_ff     <= TX_PART;
            tx_word_ff <= '0;
        end
        else if (busy_ff)
        begin
            if (pkt_done)
            begin
                busy_ff    <= 1'b0;
                ready_n_ff <= 1'b1;
            end
        end
        else if (armed_ff || pending)
        begin
            busy_ff    <= 1'b1;
            ready_n_ff <= 1'b0;
            if (!en_ff)
            begin
                src_ff     <= TX_PART;
                tx_word_ff <= {`DID_PART, PART_ID};
            end
            else if (usr_full_ff)
            begin
                src_ff     <= TX_USER;
                tx_word_ff <= usr_word_ff;
            end
            else
            begin
                src_ff     <= TX_STATUS;
                tx_word_ff <= {`DID_STATUS, status_info};
            end
        end
    end

    // part id is requested once per disable; a new disable asks again
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            pid_sent_ff <= 1'b0;
        else if (pkt_done && kind != HK_CHECKSUM && kind != HK_SPECIAL)
            pid_sent_ff <= 1'b0;
        else if (pkt_done && busy_ff && src_ff == TX_PART)
            pid_sent_ff <= 1'b1;
    end

    // single holding word; ready is registered, so it lags one cycle
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            usr_full_ff <= 1'b0;
            usr_word_ff <= '0;
            tx_ready    <= 1'b0;
        end
        else
        begin
            if (usr_load)
            begin
                usr_full_ff <= 1'b1;
                usr_word_ff <= tx_data;
            end
            else if (usr_take)
                usr_full_ff <= 1'b0;
            tx_ready <= !(usr_load || (usr_full_ff && !usr_take));
        end
    end

    assign lnk.ready_n = ready_n_ff;

endmodule

// file: hw/pager_host_end.sv
`timescale 1ns/1ps
`include "pager_link_defines.svh"

module pager_host_end
    import pager_link_pkg::*;
#(
    parameter int HALF_CYC = `SCK_HALF_CYC,   // sck half period in clk_sys cycles
    parameter int GAP      = `GAP_CYC         // idle cycles after each packet
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    pager_link_if.host       lnk,
    input  wire logic        cmd_valid,
    input  wire pkt_t        cmd_data,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output pkt_t             rsp_data
);

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    // miso passes two flops, so a low phase shorter than four cycles is unsafe
    if (HALF_CYC < 4 || GAP < 8 || HALF_CYC > 255 || GAP > 255)
    begin : g_bad_timing
        $error("HALF_CYC must be 4..255 and GAP 8..255");
    end

    typedef enum {ST_IDLE, ST_DESEL, ST_WAIT, ST_SHIFT, ST_GAP} hst_e;

    hst_e             st_ff;
    logic [7:0]       tmr_ff;        // phase and gap timer
    logic [`CNT_W-1:0] bit_ff;       // bits done
    pkt_t             tx_ff;         // outgoing shifter
    pkt_t             rx_ff;         // incoming shifter
    logic             own_ff;        // packet started by this host
    logic             rdy_s1_ff, rdy_s2_ff;
    logic             miso_s1_ff, miso_s2_ff;
    logic             ss_n_ff, sck_ff;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            {rdy_s1_ff, rdy_s2_ff, miso_s1_ff, miso_s2_ff} <= 4'hf;
        else
            {rdy_s1_ff, rdy_s2_ff, miso_s1_ff, miso_s2_ff} <=
                {lnk.ready_n, rdy_s1_ff, lnk.miso_pin, miso_s1_ff};
    end

    // ----------------------------------------
    // transfer sequencer
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_ff     <= ST_IDLE;
            tmr_ff    <= 8'h00;
            bit_ff    <= '0;
            tx_ff     <= '0;
            rx_ff     <= '0;
            own_ff    <= 1'b0;
            ss_n_ff   <= 1'b1;
            sck_ff    <= 1'b0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            cmd_ready <= 1'b0;
            unique case (st_ff)
                ST_IDLE:
                    // a reserved id is accepted and dropped so it never reaches the link
                    if (cmd_valid && host_kind(cmd_data[`ID_MSB:`ID_LSB]) == HK_RESERVED)
                        cmd_ready <= 1'b1;
                    else if (cmd_valid)
                    begin
                        // a host packet always needs a fresh select fall
                        tx_ff     <= cmd_data;
                        own_ff    <= 1'b1;
                        cmd_ready <= 1'b1;
                        ss_n_ff   <= 1'b1;
                        tmr_ff    <= 8'(GAP);
                        st_ff     <= ST_DESEL;
                    end
                    else if (!rdy_s2_ff)
                    begin
                        tx_ff   <= {`HID_CHECKSUM, `INFO_W'(0)};
                        own_ff  <= 1'b0;
                        ss_n_ff <= 1'b0;
                        st_ff   <= ST_WAIT;
                    end
                ST_DESEL:
                    if (tmr_ff == 8'h00)
                    begin
                        ss_n_ff <= 1'b0;
                        st_ff   <= ST_WAIT;
                    end
                    else
                        tmr_ff <= tmr_ff - 8'h01;
                ST_WAIT:
                    if (!rdy_s2_ff)
                    begin
                        bit_ff <= '0;
                        tmr_ff <= 8'(HALF_CYC - 1);
                        st_ff  <= ST_SHIFT;
                    end
                ST_SHIFT:
                    if (tmr_ff != 8'h00)
                        tmr_ff <= tmr_ff - 8'h01;
                    else if (!sck_ff)
                    begin
                        // rising edge: device samples mosi, host takes miso
                        sck_ff <= 1'b1;
                        rx_ff  <= {rx_ff[`PKT_W-2:0], miso_s2_ff};
                        tmr_ff <= 8'(HALF_CYC - 1);
                    end
                    else
                    begin
                        sck_ff <= 1'b0;
                        tx_ff  <= {tx_ff[`PKT_W-2:0], 1'b0};
                        tmr_ff <= 8'(HALF_CYC - 1);
                        bit_ff <= bit_ff + `CNT_W'(1);
                        if (bit_ff == '1)
                        begin
                            rsp_valid <= 1'b1;
                            rsp_data  <= rx_ff;
                            ss_n_ff   <= own_ff ? 1'b1 : ss_n_ff;
                            tmr_ff    <= 8'(GAP);
                            st_ff     <= ST_GAP;
                        end
                    end
                ST_GAP:
                    // lets the device's ready rise before it is looked at again
                    if (tmr_ff == 8'h00)
                        st_ff <= ST_IDLE;
                    else
                        tmr_ff <= tmr_ff - 8'h01;
                default:
                    st_ff <= ST_IDLE;
            endcase
        end
    end

    assign lnk.ss_n = ss_n_ff;
    assign lnk.sck  = sck_ff;
    assign lnk.mosi = tx_ff[`PKT_W-1];

endmodule

// file: testbench/pager_decoder_spi_packet_port_sva.sv
`timescale 1ns/1ps

module pager_decoder_spi_packet_port_sva
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ss_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso_oe,
    input wire logic ready_n
);
    // ----------------------------------------
    // bit count within the current select
    // ----------------------------------------
    logic       sck_ff;  // sck one cycle ago
    logic [5:0] bits_ff; // rises seen, wraps 32 -> 1 for packets under one select

    // previous sck, for rise detection
    always_ff @(posedge clk_sys)
        sck_ff <= sck;

    // count lags the wire by a cycle; the assertions allow for that
    always_ff @(posedge clk_sys)
    begin
        if (rst || ss_n)
            bits_ff <= 6'h00;
        else if (sck && !sck_ff)
            bits_ff <= (bits_ff == 6'h20) ? 6'h01 : bits_ff + 6'h01;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // link assertions
    // ----------------------------------------
    a_sck_idle_low: assert property (ss_n [*2] |-> !sck)
        else $error("serial clock high while deselected");
    a_sck_high_len: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("serial clock high phase of wrong length");
    a_sck_low_len: assert property ($fell(sck) |-> !sck [*4])
        else $error("serial clock low phase too short");
    a_frame_len: assert property ($rose(ss_n) |-> bits_ff == 6'h20)
        else $error("deselect after a partial packet");
    a_ready_gates_clock: assert property ($rose(sck) && (bits_ff == 6'h00 || bits_ff == 6'h20)
        |-> !ready_n)
        else $error("packet clocked without ready low");
    a_mosi_stable_high: assert property (sck |-> $stable(mosi))
        else $error("host data moved while clock high");
    a_miso_driven: assert property (!ss_n && bits_ff != 6'h00 |-> miso_oe)
        else $error("device data released inside a packet");
    a_fresh_select: assert property ($rose(ss_n) |-> ss_n [*8])
        else $error("reselect came too soon");

    // main scenarios reached
    c_deselect: cover property ($rose(ss_n));
    c_request_selected: cover property ($fell(ready_n) && !ss_n);
    c_full_packet: cover property (bits_ff == 6'h20 && sck);
endmodule

// file: testbench/tb_pager_decoder_spi_packet_port.sv
`timescale 1ns/1ps

module tb_pager_decoder_spi_packet_port
    import pager_link_pkg::*;
;
    localparam info_t PART = 24'h3c5a96; // arbitrary value
    logic        clk_sys = 1'b0;
    logic        rst = 1'b0;
    logic        tx_valid = 1'b0;
    pkt_t        tx_data = '0;
    info_t       status_info = '0;
    logic        cmd_valid = 1'b0;
    pkt_t        cmd_data = '0;
    logic        tx_ready, rx_valid, out_en, cmd_ready, rsp_valid;
    pkt_t        rsp_data;
    host_kind_e  rx_kind;
    logic [3:0]  rx_index;
    info_t       rx_info;
    info_t       sum;      // value the device checksum should hold
    logic [31:0] exp_q[$]; // reads owed by the host end
    logic [31:0] rx_q[$];  // deliveries owed by the device end
    int          seed = 96;
    int          got = 0;
    int          fails = 0;
    int          check_count = 0;
    int          cycles = 0;

    pager_link_if lnk ();

    pager_dev_end #(.PART_ID(PART)) u_pager_dev_end
    (
        .clk_sys(clk_sys), .rst(rst), .lnk(lnk.device), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .status_info(status_info),
        .rx_valid(rx_valid), .rx_kind(rx_kind), .rx_index(rx_index),
        .rx_info(rx_info), .out_en(out_en)
    );

    pager_host_end u_pager_host_end
    (
        .clk_sys(clk_sys), .rst(rst), .lnk(lnk.host), .cmd_valid(cmd_valid),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data)
    );

    pager_decoder_spi_packet_port_sva u_pager_decoder_spi_packet_port_sva
    (
        .clk_sys(clk_sys), .rst(rst), .ss_n(lnk.ss_n), .sck(lnk.sck),
        .mosi(lnk.mosi), .miso_oe(lnk.miso_oe), .ready_n(lnk.ready_n)
    );

    // ----------------------------------------
    // clock, compare and verdict
    // ----------------------------------------
    initial
        forever #4 clk_sys = ~clk_sys;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watch both user outputs; anything not owed compares against unknown
    always @(posedge clk_sys)
    begin
        if (rsp_valid === 1'b1)
        begin
            check(rsp_data, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
            got++;
        end
        if (rx_valid === 1'b1)
            check({rx_kind, rx_index, rx_info}, rx_q.size() != 0 ? rx_q.pop_front() : 'x);
    end

    // hang guard, well above the roughly 39k cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            fails++;
            results;
        end
    end

    // ----------------------------------------
    // drivers
    // ----------------------------------------
    // note a read and wait for it, then let the device settle its state
    task automatic want(input pkt_t e);
        int n;
        n = got;
        exp_q.push_back(e);
        wait (got != n);
        repeat (8) @(posedge clk_sys);
        #1;
    endtask

    // one host-started packet; cmd_valid held until the accept pulse is seen
    task automatic xfer(input pkt_t p, input pkt_t e);
        cmd_data = p;
        cmd_valid = 1'b1;
        do @(posedge clk_sys) #1; while (cmd_ready !== 1'b1);
        cmd_valid = 1'b0;
        want(e);
    endtask

    // counted packet, the part id read it provokes, then the re-enabling checksum
    task automatic cfg(input id_t id, input host_kind_e k, input logic [3:0] ix,
                       input bit dlv = 1'b1);
        info_t v;
        v = 24'($random(seed));
        status_info = 24'($random(seed));
        if (dlv)
            rx_q.push_back({k, ix, v});
        xfer({id, v}, {8'h7f, status_info});
        sum ^= v;
        check(out_en, 1'b0);
        want({8'hff, PART});
        xfer({8'h00, sum}, {8'hff, PART});
        check(out_en, 1'b1);
    endtask

    initial
    begin
        // a real rising edge of rst clears done_tgl_ff and rx_word_ff, which see no sck
        #1 rst = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1 rst = 1'b0;
        want({8'hff, PART});
        check(out_en, 1'b0);
        xfer({8'h00, PART ^ 24'h000001}, {8'hff, PART});
        check(out_en, 1'b0);
        xfer({8'h00, PART}, {8'hff, PART});
        check(out_en, 1'b1);
        sum = PART;
        xfer(32'h00000000, {8'h7f, status_info});
        check(out_en, 1'b1);
        // device-started read of a queued word, answered by a null checksum
        tx_data = {8'h01, 24'($random(seed))};
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1) @(posedge clk_sys) #1;
        @(posedge clk_sys) #1;
        tx_valid = 1'b0;
        want(tx_data);
        check(out_en, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            status_info = 24'($random(seed));
            xfer({8'(8'h1c + i), 24'($random(seed))}, {8'h7f, status_info});
            check(out_en, 1'b1);
        end
        cfg(8'h01, HK_CONFIG, 4'h1);
        cfg(8'h02, HK_CONTROL, 4'h2);
        cfg(8'h03, HK_ALLFRAME, 4'h3);
        cfg(8'h0f, HK_RXLINE, 4'hf);
        for (int i = 0; i < 12; i++)
            cfg(8'(8'h10 + i), HK_RXCFG, 4'(i));
        for (int i = 0; i < 8; i++)
            cfg(8'(8'h20 + i), HK_FRAME, 4'(7 - i));
        cfg(8'h78, HK_UADDR_EN, 4'h8);
        for (int i = 0; i < 16; i++)
            cfg(8'(8'h80 + i), HK_UADDR, 4'(i));
        // reserved id is taken by the host end and dropped, never sent
        cmd_data = {8'h28, 24'($random(seed))};
        cmd_valid = 1'b1;
        do @(posedge clk_sys) #1; while (cmd_ready !== 1'b1);
        cmd_valid = 1'b0;
        repeat (400) @(posedge clk_sys);
        #1;
        check(lnk.ss_n, 1'b1);
        check(out_en, 1'b1);
        results;
    end
endmodule
